// ---- src/iorl_axi_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module iorl_axi_slave (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data.
  input wire logic [iorl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data.
  input wire logic [iorl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side.
  output iorl_pkg::iorl_reg_wr_type reg_wr,
  output logic [iorl_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data
);

  typedef struct packed {
    logic aw_have;
    logic [iorl_pkg::ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rd_pend;
    logic [iorl_pkg::ADDR_W-1:0] rd_addr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    iorl_pkg::iorl_reg_wr_type wr;
  } iorl_axi_state_type;

  iorl_axi_state_type st;
  iorl_axi_state_type next_st;

  // Ready flags are computed from the next state so every output is a flop.
  always_comb begin
    next_st = st;
    next_st.wr.en = 1'b0;
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_have = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_have = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Both halves held: commit once and answer in the same cycle.
    if (st.aw_have && st.w_have && !st.bvalid) begin
      next_st.wr.en = iorl_pkg::iorl_mapped(st.awaddr);
      next_st.wr.addr = st.awaddr;
      next_st.wr.data = st.wdata;
      next_st.wr.strb = st.wstrb;
      next_st.bvalid = 1'b1;
      next_st.bresp = iorl_pkg::iorl_mapped(st.awaddr) ? iorl_pkg::RESP_OKAY
                                                        : iorl_pkg::RESP_SLVERR;
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
    end
    next_st.awready = !next_st.aw_have && !next_st.bvalid;
    next_st.wready = !next_st.w_have && !next_st.bvalid;
    // Read: decode one cycle, then register the data.
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (st.rd_pend) begin
      next_st.rd_pend = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_data;
      next_st.rresp = iorl_pkg::iorl_mapped(st.rd_addr) ? iorl_pkg::RESP_OKAY
                                                         : iorl_pkg::RESP_SLVERR;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rd_pend = 1'b1;
      next_st.rd_addr = s_axi_araddr;
    end
    next_st.arready = !next_st.rd_pend && !next_st.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign reg_wr = st.wr;
  assign rd_addr = st.rd_addr;

endmodule // iorl_axi_slave
`default_nettype wire

// ---- src/iorl_pkg.sv ----
// How it works
// - Start input sets output 0, stop input clears it; state holds between.
// - Latch output ANDs inverted stop input with latch flag.
// - Sequence trigger sets output 0 and starts timer 0.
// - Outputs 1 to 5 follow in turn, each after its own delay.
// - Sequence outputs stay latched high.
// - Output 0 high only while all twelve inputs are high.
// - A rule takes at most three inputs; wider functions cascade.
// - Pass-to-following-rule chaining joins only adjacent rules.
// - Flag cascade links any two rules.
// - Flicker inverts flag 0 every 0.5 s; another rule copies it out.
// - One-shot: rise of input 0 sets output 0.
// - One-shot output drops after one second though input stays high.
// - Flag 0 starts false; edge starts timer 0; expiry sets flag, clears output.
// - One rule's pin-to-pin response stays under three milliseconds.
// - Scan runs inputs and logic, execution, outputs; flags seen next scan.
// - Sixteen rules, in rule-number order within each stage.
package iorl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned SCAN_PERIOD_US = 1000;
  localparam int unsigned SCAN_CYCLES = CLK_FREQ_HZ / 1_000_000 * SCAN_PERIOD_US;
  localparam int unsigned FLICK_PERIOD_MS = 500;
  localparam int unsigned FLICK_SCANS = FLICK_PERIOD_MS * 1000 / SCAN_PERIOD_US;
  localparam int unsigned PULSE_PERIOD_MS = 1000;
  localparam int unsigned PULSE_SCANS = PULSE_PERIOD_MS * 1000 / SCAN_PERIOD_US;
  localparam int unsigned SEQ_DELAY_S = 5;
  localparam int unsigned SEQ_DELAY_SCANS = SEQ_DELAY_S * 1_000_000 / SCAN_PERIOD_US;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes.
  localparam int unsigned NUM_INPUTS = 12;
  localparam int unsigned NUM_OUTPUTS = 6;
  localparam int unsigned NUM_RULES = 16;
  localparam int unsigned NUM_FLAGS = 4;
  localparam int unsigned RULE_INPUTS = 3;
  localparam int unsigned SEQ_STAGES = 5;
  localparam int unsigned TIMER_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MODE_W = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map and fields.
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RULE_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_INPUTS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_TIMER0 = 8'h14;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_RESET_BIT = 1;
  localparam int unsigned STAT_OUT_LSB = 0;
  localparam int unsigned STAT_FLAG_LSB = 8;
  localparam int unsigned STAT_TRUN_BIT = 16;
  localparam logic [NUM_RULES-1:0] RULE_ENABLE_RESET = 16'hFFFF;
  localparam logic RUN_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pattern loaded into the rule engine.
  typedef enum logic [MODE_W-1:0] {
    MODE_IDLE = 3'h0,
    MODE_LATCH = 3'h1,
    MODE_SEQUENCE = 3'h3,
    MODE_AND12 = 3'h2,
    MODE_FLICKER = 3'h6,
    MODE_ONE_SHOT = 3'h7
  } iorl_mode_type;

  // One register write, issued for a single cycle.
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } iorl_reg_wr_type;

  // True for every implemented register word.
  function automatic logic iorl_mapped(input logic [ADDR_W-1:0] a);
    return (a == ADDR_MODE) || (a == ADDR_CONTROL) || (a == ADDR_RULE_ENABLE) ||
           (a == ADDR_STATUS) || (a == ADDR_INPUTS) || (a == ADDR_TIMER0);
  endfunction

  // Merge write data into an old word by byte strobes.
  function automatic logic [31:0] iorl_merge(input logic [31:0] old_word,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ---- src/iorl_rule_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module iorl_rule_engine #(
  parameter int unsigned SCAN_CYCLES = iorl_pkg::SCAN_CYCLES,
  parameter int unsigned FLICK_SCANS = iorl_pkg::FLICK_SCANS,
  parameter int unsigned PULSE_SCANS = iorl_pkg::PULSE_SCANS,
  parameter logic [iorl_pkg::SEQ_STAGES-1:0][31:0] SEQ_SCANS =
    {iorl_pkg::SEQ_STAGES{32'(iorl_pkg::SEQ_DELAY_SCANS)}}
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Field pins.
  input wire logic [iorl_pkg::NUM_INPUTS-1:0] digital_input,
  output logic [iorl_pkg::NUM_OUTPUTS-1:0] digital_output,
  // AXI4-Lite write channels.
  input wire logic [iorl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [iorl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int unsigned NI = iorl_pkg::NUM_INPUTS;
  localparam int unsigned NO = iorl_pkg::NUM_OUTPUTS;
  localparam int unsigned NR = iorl_pkg::NUM_RULES;
  localparam int unsigned NF = iorl_pkg::NUM_FLAGS;
  localparam int unsigned RI = iorl_pkg::RULE_INPUTS;
  localparam int unsigned NS = iorl_pkg::SEQ_STAGES;
  localparam int unsigned TW = iorl_pkg::TIMER_W;
  localparam int unsigned AND_RULES = NI / RI;

  // Whole engine state.
  typedef struct packed {
    logic [NI-1:0] sync1;
    logic [NI-1:0] sync2;
    logic [NI-1:0] sample;
    logic [NI-1:0] prev;
    logic [31:0] scan_cnt;
    logic tick;
    logic [31:0] flick_cnt;
    iorl_pkg::iorl_mode_type mode;
    logic run;
    logic mod_rst;
    logic [NR-1:0] rule_en;
    logic [NF-1:0] flag;
    logic [NO-1:0] dout;
  } iorl_engine_state_type;

  iorl_engine_state_type st;
  iorl_engine_state_type next_st;

  iorl_pkg::iorl_reg_wr_type reg_wr;
  logic [iorl_pkg::ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic [TW-1:0] timer_count;
  logic timer_running;
  logic timer_start;
  logic timer_stop;
  logic rise0;
  logic [AND_RULES-1:0] and_link;
  logic [NS-1:0][31:0] seq_cum;
  logic [NS-1:0] seq_due;
  logic [31:0] ctrl_word;
  logic [31:0] mode_word;
  logic [31:0] en_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave and timer 0.

  iorl_axi_slave u_axi (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr(reg_wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  iorl_timer #(
    .W(TW)
  ) u_timer0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(st.tick),
    .start(timer_start),
    .stop(timer_stop),
    .count(timer_count),
    .running(timer_running)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Derived rule conditions, taken from the scan sample and from timer 0.

  // Rises are seen between scan samples; a pulse shorter than a scan may be missed.
  assign rise0 = st.sample[0] && !st.prev[0];

  // Each AND rule sees three inputs; all but the last pass their result to the rule after it.
  generate
    for (genvar k = 0; k < AND_RULES; k++) begin : g_and
      if (k == 0) begin : g_first
        assign and_link[k] = st.rule_en[k] && (&st.sample[k*RI +: RI]);
      end else begin : g_next
        assign and_link[k] = and_link[k-1] && st.rule_en[k] &&
                             (&st.sample[k*RI +: RI]);
      end
    end
  endgenerate

  // Thresholds accumulate: stage k waits its delay after stage k-1.
  generate
    for (genvar k = 0; k < NS; k++) begin : g_seq
      if (k == 0) begin : g_first
        assign seq_cum[k] = SEQ_SCANS[k];
      end else begin : g_next
        assign seq_cum[k] = seq_cum[k-1] + SEQ_SCANS[k];
      end
      assign seq_due[k] = timer_running &&
                          (32'(timer_count) >= (seq_cum[k] - 32'h1));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Register read decode.

  assign ctrl_word = 32'({st.run}) << iorl_pkg::CTRL_RUN_BIT;
  assign mode_word = 32'(st.mode);
  assign en_word = 32'(st.rule_en);

  // Unmapped addresses read as zero; the slave flags them with SLVERR.
  always_comb begin
    rd_data = 32'h0;
    case (rd_addr)
      iorl_pkg::ADDR_MODE: rd_data = mode_word;
      iorl_pkg::ADDR_CONTROL: rd_data = ctrl_word;
      iorl_pkg::ADDR_RULE_ENABLE: rd_data = en_word;
      iorl_pkg::ADDR_STATUS: begin
        rd_data[iorl_pkg::STAT_OUT_LSB +: NO] = st.dout;
        rd_data[iorl_pkg::STAT_FLAG_LSB +: NF] = st.flag;
        rd_data[iorl_pkg::STAT_TRUN_BIT] = timer_running;
      end
      iorl_pkg::ADDR_INPUTS: rd_data = 32'(st.sample);
      iorl_pkg::ADDR_TIMER0: rd_data = 32'(timer_count);
      default: rd_data = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: pins, scan pacing, registers, then the rule scan.

  always_comb begin
    logic [31:0] w;
    w = 32'h0;
    next_st = st;
    timer_start = 1'b0;
    timer_stop = 1'b0;
    next_st.mod_rst = 1'b0;

    // Two-flop synchroniser; only sync2 is read further on.
    next_st.sync1 = digital_input;
    next_st.sync2 = st.sync1;

    // One scan per SCAN_CYCLES bounds pin-to-pin delay.
    next_st.tick = 1'b0;
    if (st.scan_cnt >= 32'(SCAN_CYCLES - 1)) begin
      next_st.scan_cnt = 32'h0;
      next_st.tick = 1'b1;
      next_st.sample = st.sync2;
      next_st.prev = st.sample;
    end else begin
      next_st.scan_cnt = st.scan_cnt + 32'h1;
    end

    // Register writes. A mode change also restarts the pattern from a clean state.
    if (reg_wr.en) begin
      case (reg_wr.addr)
        iorl_pkg::ADDR_MODE: begin
          w = iorl_pkg::iorl_merge(mode_word, reg_wr.data, reg_wr.strb);
          case (w[iorl_pkg::MODE_W-1:0])
            iorl_pkg::MODE_LATCH,
            iorl_pkg::MODE_SEQUENCE,
            iorl_pkg::MODE_AND12,
            iorl_pkg::MODE_FLICKER,
            iorl_pkg::MODE_ONE_SHOT: begin
              next_st.mode = iorl_pkg::iorl_mode_type'(w[iorl_pkg::MODE_W-1:0]);
            end
            default: next_st.mode = iorl_pkg::MODE_IDLE;
          endcase
          next_st.mod_rst = 1'b1;
        end
        iorl_pkg::ADDR_CONTROL: begin
          w = iorl_pkg::iorl_merge(ctrl_word, reg_wr.data, reg_wr.strb);
          next_st.run = w[iorl_pkg::CTRL_RUN_BIT];
          next_st.mod_rst = reg_wr.strb[0] && reg_wr.data[iorl_pkg::CTRL_RESET_BIT];
        end
        iorl_pkg::ADDR_RULE_ENABLE: begin
          w = iorl_pkg::iorl_merge(en_word, reg_wr.data, reg_wr.strb);
          next_st.rule_en = w[NR-1:0];
        end
        default: begin
        end
      endcase
    end

    if (st.mod_rst) begin
      // Module reset: flags cleared, timer stopped at zero, outputs low.
      next_st.flag = '0;
      next_st.dout = '0;
      next_st.flick_cnt = 32'h0;
      timer_stop = 1'b1;
    end else if (st.tick && st.run) begin
      // Reads below see flags registered at the end of the last scan,
      // so a flag written now is seen one scan later.
      // The rule-number order within each stage is the order of the code.
      case (st.mode)
        iorl_pkg::MODE_LATCH: begin
          // Rule 0 seals the start request into flag 0 until stop.
          if (st.rule_en[0]) begin
            next_st.flag[0] = st.sample[0] || (st.flag[0] && !st.sample[1]);
          end
          // Rule 1 drives the output from inverted stop AND flag 0.
          if (st.rule_en[1]) begin
            next_st.dout[0] = !st.sample[1] && st.flag[0];
          end
        end
        iorl_pkg::MODE_SEQUENCE: begin
          // Rule 0: the trigger lights output 0 and starts timer 0.
          if (st.rule_en[0] && rise0) begin
            next_st.dout[0] = 1'b1;
            timer_start = 1'b1;
          end
          // Rules 1 to 5 only ever set their outputs, so each one latches.
          for (int k = 0; k < NS; k++) begin
            if (st.rule_en[k+1] && seq_due[k]) begin
              next_st.dout[k+1] = 1'b1;
            end
          end
        end
        iorl_pkg::MODE_AND12: begin
          // The last rule of the chain owns output 0.
          if (st.rule_en[AND_RULES-1]) begin
            next_st.dout[0] = and_link[AND_RULES-1];
          end
        end
        iorl_pkg::MODE_FLICKER: begin
          // Rule 0 runs on its own execution period and inverts flag 0.
          if (st.rule_en[0]) begin
            if (st.flick_cnt >= 32'(FLICK_SCANS - 1)) begin
              next_st.flick_cnt = 32'h0;
              next_st.flag[0] = !st.flag[0];
            end else begin
              next_st.flick_cnt = st.flick_cnt + 32'h1;
            end
          end
          // Rule 1 copies flag 0 to the output every scan.
          if (st.rule_en[1]) begin
            next_st.dout[0] = st.flag[0];
          end
        end
        iorl_pkg::MODE_ONE_SHOT: begin
          // Rule 0: the edge restarts timer 0 and rearms flag 0 as false.
          if (st.rule_en[0] && rise0) begin
            timer_start = 1'b1;
            next_st.flag[0] = 1'b0;
          end else if (st.rule_en[1] && timer_running &&
                       (32'(timer_count) >= 32'(PULSE_SCANS - 2))) begin
            // Rule 1: expiry sets flag 0 one scan early to cover its visibility delay.
            next_st.flag[0] = 1'b1;
            timer_stop = 1'b1;
          end
          // Rule 2: an edge lights the output; a true flag 0 puts it out.
          if (st.rule_en[2]) begin
            if (rise0) begin
              next_st.dout[0] = 1'b1;
            end else if (st.flag[0]) begin
              next_st.dout[0] = 1'b0;
            end
          end
        end
        default: begin
          next_st.dout = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  // Synchronous reset idles every flag, output and count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.mode <= iorl_pkg::MODE_IDLE;
      st.run <= iorl_pkg::RUN_RESET;
      st.rule_en <= iorl_pkg::RULE_ENABLE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign digital_output = st.dout;

endmodule // iorl_rule_engine
`default_nettype wire

// ---- src/iorl_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module iorl_timer #(
  parameter int unsigned W = 32
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Control.
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  // State.
  output logic [W-1:0] count,
  output logic running
);

  typedef struct packed {
    logic [W-1:0] count;
    logic running;
  } iorl_timer_state_type;

  iorl_timer_state_type st;
  iorl_timer_state_type next_st;

  // Stop beats start so a module reset leaves the timer idle.
  always_comb begin
    next_st = st;
    if (stop) begin
      next_st.count = '0;
      next_st.running = 1'b0;
    end else if (start) begin
      next_st.count = '0;
      next_st.running = 1'b1;
    end else if (tick && st.running && (st.count != {W{1'b1}})) begin
      next_st.count = st.count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;
  assign running = st.running;

endmodule // iorl_timer
`default_nettype wire

// ---- test/iorl_field.sv ----
`timescale 1ns/1ps
`default_nettype none
module iorl_field (
  // Switches.
  input wire logic [11:0] sw,
  output logic [11:0] digital_input,
  // Actuators.
  input wire logic [5:0] digital_output,
  output logic [5:0] lamp
);
  // Switches are clean levels; contact bounce is not modelled.
  assign digital_input = sw;
  assign lamp = digital_output;
endmodule // iorl_field
`default_nettype wire

// ---- test/iorl_rule_engine_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module iorl_rule_engine_checker (
  // Clock, reset and pins.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] digital_output,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // All checks run on aclk; all but rst_out_a rest during reset.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##[0:2] s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> ##[0:2] s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // Reset must win at once, so this one is not disabled by it.
  rst_out_a: assert property (disable iff (1'b0) !aresetn |=> digital_output == 6'h00)
    else $error("outputs not cleared by reset");
  wr_c: cover property (s_axi_bvalid && s_axi_bready);
  rd_c: cover property (s_axi_rvalid && s_axi_rready);
  seq_c: cover property ($rose(digital_output[5]));
endmodule // iorl_rule_engine_checker
bind iorl_rule_engine iorl_rule_engine_checker u_iorl_rule_engine_checker (.aclk(aclk),
  .aresetn(aresetn), .digital_output(digital_output), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire

// ---- test/iorl_rule_engine_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module iorl_rule_engine_test;
  localparam int SC = 8;
  localparam logic [1:0] OK = iorl_pkg::RESP_OKAY;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] sw = '0;
  logic [11:0] din;
  logic [5:0] dout, lamp;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fail_count = 0, cmp_count = 0;
  // A 50 ns half period gives 10 MHz.
  always #50 aclk = ~aclk;
  // Short counts keep the run brief; expectations use the same figures.
  iorl_rule_engine #(.SCAN_CYCLES(SC), .FLICK_SCANS(4), .PULSE_SCANS(3),
    .SEQ_SCANS({5{32'h3}})) u_iorl_rule_engine (.aclk(aclk), .aresetn(aresetn),
    .digital_input(din), .digital_output(dout), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  iorl_field u_iorl_field (.sw(sw), .digital_input(din), .digital_output(dout), .lamp(lamp));
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic lose;
    fail_count++;
    $display("unexpected at %0t: wait ran out", $time);
    final_report;
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic step(input logic [11:0] s, input logic [31:0] e);
    sw <= s;
    clk(3 * SC);
    chk(32'(lamp), e);
  endtask
  // Address and data go out together; each drops when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      n++;
      if (n > 40) lose;
    end while (!bvalid);
    chk(32'(bresp), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n = 0;
    araddr <= a;
    arvalid <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      n++;
      if (n > 40) lose;
    end while (!rvalid);
    chk(rdata, e);
    chk(32'(rresp), 32'(r));
  endtask
  task automatic setm(input iorl_pkg::iorl_mode_type m);
    wr(iorl_pkg::ADDR_MODE, 32'(m), OK);
  endtask
  // Counts cycles until an output reaches a level.
  task automatic wt(input int b, input logic v, output int n);
    n = 0;
    while (lamp[b] !== v) begin
      @(posedge aclk);
      n++;
      if (n > 400) lose;
    end
  endtask
  task automatic t_reset;
    rd(iorl_pkg::ADDR_MODE, 32'h0, OK);
    rd(iorl_pkg::ADDR_RULE_ENABLE, 32'hFFFF, OK);
    rd(8'h18, 32'h0, iorl_pkg::RESP_SLVERR);
    wr(8'h18, 32'h1, iorl_pkg::RESP_SLVERR);
    chk(32'(lamp), 32'h0);
    $display("reset test done");
  endtask
  task automatic t_latch;
    setm(iorl_pkg::MODE_LATCH);
    step(12'h001, 32'h1);
    step(12'h000, 32'h1);
    step(12'h003, 32'h0);
    step(12'h001, 32'h1);
    sw <= 12'h000;
    wr(iorl_pkg::ADDR_CONTROL, 32'h3, OK);
    clk(3 * SC);
    rd(iorl_pkg::ADDR_STATUS, 32'h0, OK);
    $display("latch test done");
  endtask
  task automatic t_seq;
    int n;
    setm(iorl_pkg::MODE_SEQUENCE);
    clk(2 * SC);
    sw <= 12'h001;
    wt(0, 1, n);
    // Sample midway between steps so scan phase cannot matter.
    for (int k = 0; k < 6; k++) begin
      clk(k == 0 ? SC + SC / 2 : 3 * SC);
      chk(32'(lamp), (32'h1 << (k + 1)) - 32'h1);
    end
    sw <= 12'h000;
    clk(4 * SC);
    chk(32'(lamp), 32'h3F);
    aresetn <= 0;
    clk(3);
    chk(32'(lamp), 32'h0);
    aresetn <= 1;
    clk(2);
    $display("sequence test done");
  endtask
  task automatic t_and;
    setm(iorl_pkg::MODE_AND12);
    step(12'hFFF, 32'h1);
    for (int i = 0; i < 12; i++) begin
      step(12'hFFF ^ (12'h001 << i), 32'h0);
    end
    $display("and test done");
  endtask
  task automatic t_flick;
    int n;
    setm(iorl_pkg::MODE_FLICKER);
    wt(0, 1, n);
    wt(0, 0, n);
    chk(32'(n), 32'(4 * SC));
    wt(0, 1, n);
    chk(32'(n), 32'(4 * SC));
    $display("flicker test done");
  endtask
  task automatic t_pulse;
    int n;
    sw <= 12'h000;
    setm(iorl_pkg::MODE_ONE_SHOT);
    clk(2 * SC);
    sw <= 12'h001;
    wt(0, 1, n);
    wt(0, 0, n);
    chk(32'(n), 32'(3 * SC));
    clk(4 * SC);
    chk(32'(lamp), 32'h0);
    $display("one-shot test done");
  endtask
  // Reset is held for eight cycles, then the scenarios run in turn.
  initial begin
    clk(8);
    aresetn <= 1;
    t_reset;
    t_latch;
    t_seq;
    t_and;
    t_flick;
    t_pulse;
    final_report;
  end
endmodule // iorl_rule_engine_test
`default_nettype wire
